// ==== si2_defines.svh ====
// constants for the second input configuration register bank
`ifndef SI2_DEFINES_SVH
`define SI2_DEFINES_SVH

// register indices; byte address is four times the index
`define SI2_IDX_HIGH      10'h023
`define SI2_IDX_LOW       10'h024
`define SI2_IDX_RATIO     10'h025
`define SI2_IDX_BIAS      10'h026
`define SI2_IDX_FILTER    10'h02B
`define SI2_IDX_TYPE      10'h0AA
`define SI2_IDX_CHAR      10'h0AB
`define SI2_IDX_STATUS    10'h0B0

// status register fields
`define SI2_STS_FIELDCAL  0
`define SI2_STS_REJECT    1

// widths
`define SI2_FP_W          32
`define SI2_INT_W         16
`define SI2_IDX_W         10

// reset values
`define SI2_RST_HIGH      32'h42C80000
`define SI2_RST_LOW       32'h00000000
`define SI2_RST_RATIO     32'h3F800000
`define SI2_RST_BIAS      32'h00000000
`define SI2_RST_FILTER    32'h00000000
`define SI2_RST_TYPE      16'h0000
`define SI2_RST_CHAR      16'h0019

// single precision bounds
`define SI2_FP_M999       32'hC479C000
`define SI2_FP_9999       32'h461C3C00
`define SI2_FP_M20        32'hC1A00000
`define SI2_FP_20         32'h41A00000
`define SI2_FP_ZERO       32'h00000000
`define SI2_FP_120        32'h42F00000

// highest characterization code (square root)
`define SI2_CHAR_MAX      16'h001A

`endif

// ==== si2_pkg.sv ====
// types for the second input configuration register bank
`include "si2_defines.svh"
package si2_pkg;

  typedef enum logic [15:0] {
    SI2_TYPE_DISABLED = 16'h0000,
    SI2_TYPE_MA_0_20  = 16'h001A,
    SI2_TYPE_MA_4_20  = 16'h001B,
    SI2_TYPE_V_0_5    = 16'h001F,
    SI2_TYPE_V_1_5    = 16'h0020,
    SI2_TYPE_V_0_2    = 16'h0023
  } si2_sigtype_e;

  typedef struct packed {
    logic [`SI2_FP_W-1:0]  rangeHigh;
    logic [`SI2_FP_W-1:0]  rangeLow;
    logic [`SI2_FP_W-1:0]  ratio;
    logic [`SI2_FP_W-1:0]  bias;
    logic [`SI2_FP_W-1:0]  filterTime;
    logic [`SI2_INT_W-1:0] sigType;
    logic [`SI2_INT_W-1:0] charCode;
  } si2_cfg_s;

  typedef struct packed {
    si2_cfg_s              cfg;
    logic                  fieldCal;
    logic                  rejectLast;
    logic                  calRestore;
    logic                  pready;
    logic                  pslverr;
    logic [`SI2_FP_W-1:0]  prdata;
  } si2_state_s;

endpackage

// ==== si2_fp_range.sv ====
// single precision range check, bounds inclusive
`timescale 1ns/100ps
`include "si2_defines.svh"
module si2_fp_range
(
  // operands
  input  wire logic [`SI2_FP_W-1:0] value,
  input  wire logic [`SI2_FP_W-1:0] lowBound,
  input  wire logic [`SI2_FP_W-1:0] highBound,
  // result
  output logic                      inRange
);

  // maps a float onto an unsigned key with the same ordering
  function automatic logic [`SI2_FP_W-1:0] fpKey(
    input logic [`SI2_FP_W-1:0] f);
    logic [`SI2_FP_W-1:0] k;
    k = f[`SI2_FP_W-1] ? ~f : (f | 32'h80000000);
    // minus zero counts as zero so the zero bound admits it
    if (f == 32'h80000000)
      k = 32'h80000000;
    return k;
  endfunction

  logic notFinite;

  always_comb
  begin
    // nan and infinity never fit any setting
    notFinite = (value[30:23] == 8'hFF);
    inRange   = !notFinite &&
                (fpKey(value) >= fpKey(lowBound)) &&
                (fpKey(value) <= fpKey(highBound));
  end

endmodule // si2_fp_range

// ==== si2_regs.sv ====
// second input configuration registers behind an apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "si2_defines.svh"
module si2_regs
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [`SI2_FP_W-1:0] pwdata,
  output logic [`SI2_FP_W-1:0]      prdata,
  output logic                      pready,
  output logic                      pslverr,
  // measurement side
  input  wire logic                 fieldCalStore,
  output si2_pkg::si2_cfg_s         cfg,
  output logic                      fieldCalActive,
  output logic                      calRestore
);

  si2_pkg::si2_state_s state_ff;
  si2_pkg::si2_state_s nxt_state;

  logic [`SI2_IDX_W-1:0] idx;
  logic [`SI2_FP_W-1:0]  loB;
  logic [`SI2_FP_W-1:0]  hiB;
  logic                  fpOk;
  logic                  setupCyc;
  logic                  commit;

  function automatic logic typeLegal(input logic [`SI2_INT_W-1:0] c);
    return c == si2_pkg::SI2_TYPE_DISABLED || c == si2_pkg::SI2_TYPE_MA_0_20
        || c == si2_pkg::SI2_TYPE_MA_4_20 || c == si2_pkg::SI2_TYPE_V_0_5
        || c == si2_pkg::SI2_TYPE_V_1_5 || c == si2_pkg::SI2_TYPE_V_0_2;
  endfunction

  function automatic logic isFloatIdx(input logic [`SI2_IDX_W-1:0] i);
    return i == `SI2_IDX_HIGH || i == `SI2_IDX_LOW || i == `SI2_IDX_RATIO
        || i == `SI2_IDX_BIAS || i == `SI2_IDX_FILTER;
  endfunction

  function automatic logic isMapped(input logic [`SI2_IDX_W-1:0] i);
    return isFloatIdx(i) || i == `SI2_IDX_TYPE || i == `SI2_IDX_CHAR
        || i == `SI2_IDX_STATUS;
  endfunction

  assign idx      = paddr[`SI2_IDX_W+1:2];
  assign setupCyc = psel && !penable;
  // write lands only on the completing access edge
  assign commit   = psel && penable && pwrite && state_ff.pready;

  // bounds follow the addressed register
  always_comb
  begin
    loB = `SI2_FP_M999;
    hiB = `SI2_FP_9999;
    if (idx == `SI2_IDX_RATIO)
    begin
      loB = `SI2_FP_M20;
      hiB = `SI2_FP_20;
    end
    else if (idx == `SI2_IDX_FILTER)
    begin
      loB = `SI2_FP_ZERO;
      hiB = `SI2_FP_120;
    end
  end

  si2_fp_range u_range
  (
    .value     (pwdata),
    .lowBound  (loB),
    .highBound (hiB),
    .inRange   (fpOk)
  );

  always_comb
  begin
    logic bad;
    logic [`SI2_INT_W-1:0] wInt;
    bad  = 1'b0;
    wInt = pwdata[`SI2_INT_W-1:0];
    nxt_state = state_ff;
    nxt_state.calRestore = 1'b0;
    nxt_state.pready     = setupCyc;
    // answer stands for the access cycle only
    nxt_state.pslverr    = 1'b0;
    nxt_state.prdata     = '0;
    if (setupCyc)
    begin
      // decide answer in setup so outputs leave flops
      bad = !isMapped(idx) || (paddr[1:0] != 2'b00);
      if (pwrite && !bad)
      begin
        if (isFloatIdx(idx))
          bad = !fpOk;
        else if (idx == `SI2_IDX_TYPE)
          bad = (pwdata[31:16] != 16'h0000) || !typeLegal(wInt);
        else if (idx == `SI2_IDX_CHAR)
          bad = (pwdata[31:16] != 16'h0000)
             || (wInt > `SI2_CHAR_MAX);
        else
          bad = 1'b1;
      end
      nxt_state.pslverr = bad;
      nxt_state.prdata  = '0;
      if (!pwrite && !bad)
      begin
        unique case (idx)
          `SI2_IDX_HIGH:   nxt_state.prdata = state_ff.cfg.rangeHigh;
          `SI2_IDX_LOW:    nxt_state.prdata = state_ff.cfg.rangeLow;
          `SI2_IDX_RATIO:  nxt_state.prdata = state_ff.cfg.ratio;
          `SI2_IDX_BIAS:   nxt_state.prdata = state_ff.cfg.bias;
          `SI2_IDX_FILTER: nxt_state.prdata = state_ff.cfg.filterTime;
          `SI2_IDX_TYPE:   nxt_state.prdata = {16'h0000, state_ff.cfg.sigType};
          `SI2_IDX_CHAR:   nxt_state.prdata = {16'h0000, state_ff.cfg.charCode};
          default:
          begin
            nxt_state.prdata[`SI2_STS_FIELDCAL] = state_ff.fieldCal;
            nxt_state.prdata[`SI2_STS_REJECT]   = state_ff.rejectLast;
          end
        endcase
      end
    end
    else if (commit)
    begin
      nxt_state.rejectLast = state_ff.pslverr;
      if (!state_ff.pslverr)
      begin
        unique case (idx)
          `SI2_IDX_HIGH:   nxt_state.cfg.rangeHigh  = pwdata;
          `SI2_IDX_LOW:    nxt_state.cfg.rangeLow   = pwdata;
          `SI2_IDX_RATIO:  nxt_state.cfg.ratio      = pwdata;
          `SI2_IDX_BIAS:   nxt_state.cfg.bias       = pwdata;
          `SI2_IDX_FILTER: nxt_state.cfg.filterTime = pwdata;
          `SI2_IDX_TYPE:
          begin
            nxt_state.cfg.sigType = wInt;
            if (wInt != state_ff.cfg.sigType)
            begin
              // field trims fit the old range only
              nxt_state.fieldCal   = 1'b0;
              nxt_state.calRestore = 1'b1;
            end
          end
          default:         nxt_state.cfg.charCode = wInt;
        endcase
      end
    end
    // a field calibration stored in the clearing cycle still wins
    if (fieldCalStore)
      nxt_state.fieldCal = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_ff                <= '0;
      state_ff.cfg.rangeHigh  <= `SI2_RST_HIGH;
      state_ff.cfg.rangeLow   <= `SI2_RST_LOW;
      state_ff.cfg.ratio      <= `SI2_RST_RATIO;
      state_ff.cfg.bias       <= `SI2_RST_BIAS;
      state_ff.cfg.filterTime <= `SI2_RST_FILTER;
      state_ff.cfg.sigType    <= `SI2_RST_TYPE;
      state_ff.cfg.charCode   <= `SI2_RST_CHAR;
    end
    else
      state_ff <= nxt_state;
  end

  assign prdata         = state_ff.prdata;
  assign pready         = state_ff.pready;
  assign pslverr        = state_ff.pslverr;
  assign cfg            = state_ff.cfg;
  assign fieldCalActive = state_ff.fieldCal;
  assign calRestore     = state_ff.calRestore;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_type_legal: assert property (
    typeLegal(state_ff.cfg.sigType))
    else $error("signal type holds an illegal code");

  chk_cal_restore: assert property (
    commit && !state_ff.pslverr && idx == `SI2_IDX_TYPE && !fieldCalStore
    && pwdata[15:0] != state_ff.cfg.sigType
    |=> calRestore && !fieldCalActive ##1 !calRestore)
    else $error("type change did not restore factory calibration");

  chk_char_range: assert property (
    state_ff.cfg.charCode <= `SI2_CHAR_MAX)
    else $error("characterization code above limit");

  chk_high_write: assert property (
    $changed(state_ff.cfg.rangeHigh) |->
    $past(commit && idx == `SI2_IDX_HIGH && fpOk))
    else $error("high range changed without a legal write");

  chk_low_bias: assert property (
    $changed(state_ff.cfg.rangeLow) || $changed(state_ff.cfg.bias) |->
    $past(commit && !state_ff.pslverr
          && (idx == `SI2_IDX_LOW || idx == `SI2_IDX_BIAS)))
    else $error("low range or bias changed without a legal write");

  chk_answer_once: assert property (
    pready |=> !pready && !pslverr && prdata == '0)
    else $error("bus answer stood longer than one cycle");

  chk_type_read: assert property (
    setupCyc && !pwrite && paddr == ADDR_W'(`SI2_IDX_TYPE * 4)
    |=> pready && !pslverr && prdata == {16'h0000, $past(cfg.sigType)})
    else $error("type register read returned wrong word");

endmodule // si2_regs

// ==== second_input_config_regs_tb_top.sv ====
// self-checking bench for the second input register bank
`timescale 1ns/100ps
`include "si2_defines.svh"
module second_input_config_regs_tb_top;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h00000000;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              fieldCalStore = 1'b0;
  si2_pkg::si2_cfg_s cfg;
  logic              fieldCalActive;
  logic              calRestore;
  logic [31:0]       rdat;
  logic              rerr;
  logic              pulse;
  int                err_count = 0;
  int                samples_checked = 0;

  always #4 clock = ~clock;

  si2_regs #(.ADDR_W(12)) dut_u
  (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fieldCalStore(fieldCalStore),
    .cfg(cfg), .fieldCalActive(fieldCalActive), .calRestore(calRestore)
  );

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  // request held until pready; idle cycle after keeps strobes clean
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clock);
    if (pready !== 1'b1)
    begin
      err_count++;
      $display("unexpected pready expected 1 seen 0");
      test_done();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    // answer must be gone, restore pulse shows, in the idle cycle
    pulse = calRestore;
    chk("pready after", 32'h0, {31'h0, pready});
    chk("pslverr after", 32'h0, {31'h0, pslverr});
    chk("prdata after", 32'h0, prdata);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d,
                    input logic bad);
    apb(1'b1, {i, 2'b00}, d);
    chk("write error", {31'h0, bad}, {31'h0, rerr});
  endtask

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h00000000);
    chk("read data", e, rdat);
    chk("read error", 32'h0, {31'h0, rerr});
  endtask

  task automatic t_reset();
    rd(`SI2_IDX_HIGH, 32'h42C80000);
    rd(`SI2_IDX_LOW, 32'h00000000);
    rd(`SI2_IDX_RATIO, 32'h3F800000);
    rd(`SI2_IDX_BIAS, 32'h00000000);
    rd(`SI2_IDX_FILTER, 32'h00000000);
    rd(`SI2_IDX_TYPE, 32'h00000000);
    rd(`SI2_IDX_CHAR, 32'h00000019);
  endtask

  // each register: a bound accepted, then a value just past one of its bounds refused
  task automatic t_float();
    logic [9:0] ix [10] = '{`SI2_IDX_HIGH, `SI2_IDX_HIGH, `SI2_IDX_LOW,
      `SI2_IDX_LOW, `SI2_IDX_BIAS, `SI2_IDX_BIAS, `SI2_IDX_RATIO,
      `SI2_IDX_RATIO, `SI2_IDX_FILTER, `SI2_IDX_FILTER};
    logic [31:0] v [10] = '{32'h461C3C00, 32'h461C4000, 32'hC479C000,
      32'hC47A0000, 32'h461C3C00, 32'hC47A0000, 32'hC1A00000,
      32'h41A80000, 32'h42F00000, 32'hBF800000};
    logic [31:0] good;
    good = 32'h00000000;
    for (int k = 0; k < 10; k++)
    begin
      wr(ix[k], v[k], k[0]);
      if (!k[0])
        good = v[k];
      rd(ix[k], good);
    end
    // minus zero counts as zero; infinity never fits
    wr(`SI2_IDX_FILTER, 32'h80000000, 1'b0);
    rd(`SI2_IDX_FILTER, 32'h80000000);
    wr(`SI2_IDX_HIGH, 32'h7F800000, 1'b1);
    chk("cfg high", 32'h461C3C00, cfg.rangeHigh);
    chk("cfg bias", 32'h461C3C00, cfg.bias);
    chk("cfg low", 32'hC479C000, cfg.rangeLow);
    chk("cfg ratio", 32'hC1A00000, cfg.ratio);
    chk("cfg filter", 32'h80000000, cfg.filterTime);
  endtask

  task automatic t_codes();
    logic [15:0] ok [6] = '{16'h001A, 16'h001B, 16'h001F, 16'h0020,
                            16'h0023, 16'h0000};
    logic [15:0] no [7] = '{16'h0001, 16'h0019, 16'h001C, 16'h001E,
                            16'h0021, 16'h0022, 16'h0024};
    foreach (ok[k])
    begin
      wr(`SI2_IDX_TYPE, {16'h0, ok[k]}, 1'b0);
      chk("cfg type", {16'h0, ok[k]}, {16'h0, cfg.sigType});
    end
    foreach (no[k])
      wr(`SI2_IDX_TYPE, {16'h0, no[k]}, 1'b1);
    wr(`SI2_IDX_TYPE, 32'h0001001A, 1'b1);
    rd(`SI2_IDX_TYPE, 32'h00000000);
    wr(`SI2_IDX_CHAR, 32'h0000001A, 1'b0);
    wr(`SI2_IDX_CHAR, 32'h0000001B, 1'b1);
    rd(`SI2_IDX_CHAR, 32'h0000001A);
    wr(`SI2_IDX_CHAR, 32'h00000000, 1'b0);
    rd(`SI2_IDX_CHAR, 32'h00000000);
    chk("cfg char", 32'h0, {16'h0, cfg.charCode});
  endtask

  task automatic t_cal();
    fieldCalStore <= 1'b1;
    @(posedge clock);
    fieldCalStore <= 1'b0;
    @(posedge clock);
    chk("field cal", 32'h1, {31'h0, fieldCalActive});
    wr(`SI2_IDX_TYPE, 32'h0000001B, 1'b0);
    chk("restore pulse", 32'h1, {31'h0, pulse});
    chk("field cal", 32'h0, {31'h0, fieldCalActive});
    wr(`SI2_IDX_TYPE, 32'h0000001B, 1'b0);
    chk("restore pulse", 32'h0, {31'h0, pulse});
    rd(`SI2_IDX_STATUS, 32'h00000000);
    wr(`SI2_IDX_STATUS, 32'h00000001, 1'b1);
    // refused status write shows in bit one
    rd(`SI2_IDX_STATUS, 32'h00000002);
  endtask

  // unmapped index and misaligned byte address both refused
  task automatic t_unmapped();
    apb(1'b0, {10'h0AC, 2'b00}, 32'h00000000);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b0, {`SI2_IDX_HIGH, 2'b01}, 32'h00000000);
    chk("misaligned error", 32'h1, {31'h0, rerr});
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_float();
    t_codes();
    t_cal();
    t_unmapped();
    test_done();
  end
endmodule // second_input_config_regs_tb_top
